// ==== rtl/ela_aligner.sv ====
// lane aligner top: splits internal accesses into external cycles
`timescale 1ns/1ps
module ela_aligner
  import ela_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        endian_strap_pin,
  input  wire logic [1:0]  bus_width,
  input  wire logic        req_valid,
  input  wire ela_req_s    req,
  output logic             req_ready,
  output logic             resp_valid,
  output logic [31:0]      resp_rdata,
  output logic             ext_valid,
  output logic             ext_write,
  output logic [31:0]      ext_addr,
  output logic [31:0]      data_out,
  output logic [3:0]       data_oe,
  input  wire logic [31:0] data_in,
  input  wire logic        ext_ack,
  output logic             write_strobe_lane0,
  output logic             write_strobe_lane1,
  output logic             write_strobe_lane2,
  output logic             write_strobe_lane3,
  output logic             sdram_mask_lane0,
  output logic             sdram_mask_lane1,
  output logic             sdram_mask_lane2,
  output logic             sdram_mask_lane3
);

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture

  logic strap_done_q;
  logic little_q;
  logic strap_done_d;
  logic little_d;

  always_comb begin
    strap_done_d = 1'b1;
    little_d     = strap_done_q ? little_q : endian_strap_pin; // R9
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_done_q <= 1'b0;
      little_q     <= 1'b0;
    end else begin
      strap_done_q <= strap_done_d;
      little_q     <= little_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  ela_state_e state_q, state_d;
  ela_req_s   req_q, req_d;
  logic [1:0] width_q, width_d;
  logic [1:0] idx_q, idx_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ready_q, ready_d;
  logic        resp_q, resp_d;
  logic        xv_q, xv_d;
  logic [31:0] xaddr_q, xaddr_d;
  logic [31:0] xdata_q, xdata_d;
  logic [3:0]  oe_q, oe_d;
  logic [3:0]  we_q, we_d;
  logic [3:0]  dqm_q, dqm_d;

  logic [3:0] lane_en;
  logic [7:0] lane_idx;
  logic [1:0] cyc_off;
  logic       last;

  ela_lane_map u_map (
    .little   (little_q),
    .width    (width_q),
    .size     (req_q.size),
    .base     (req_q.addr[1:0]),
    .cyc_idx  (idx_q),
    .lane_en  (lane_en),
    .lane_idx (lane_idx),
    .cyc_off  (cyc_off),
    .last     (last)
  );

  always_comb begin
    state_d = state_q;
    req_d   = req_q;
    width_d = width_q;
    idx_d   = idx_q;
    rdata_d = rdata_q;
    ready_d = 1'b0;
    resp_d  = 1'b0;
    xv_d    = xv_q;
    xaddr_d = xaddr_q;
    xdata_d = xdata_q;
    oe_d    = oe_q;
    we_d    = we_q;
    dqm_d   = dqm_q;
    case (state_q)
      ST_IDLE: begin
        ready_d = strap_done_q;
        if (req_valid && ready_q) begin
          req_d   = req;
          width_d = bus_width;
          idx_d   = 2'h0;
          rdata_d = DATA_RST;
          ready_d = 1'b0;
          state_d = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        // steer the current slice of the value onto its lanes
        xv_d    = 1'b1;
        xaddr_d = {req_q.addr[31:2], cyc_off};
        xdata_d = DATA_RST;
        for (int l = 0; l < LANES; l++) begin
          if (lane_en[l]) begin
            xdata_d[8*l+:8] = req_q.wdata[8*lane_idx[2*l+:2]+:8]; // R1 R2 R3 R4 R5 R6 R7 R8
          end
        end
        oe_d    = req_q.write ? lane_en : LANES_OFF;
        we_d    = req_q.write ? lane_en : LANES_OFF;
        dqm_d   = ~lane_en;
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (ext_ack) begin
          for (int l = 0; l < LANES; l++) begin
            if (lane_en[l]) begin
              rdata_d[8*lane_idx[2*l+:2]+:8] = data_in[8*l+:8]; // R10
            end
          end
          xv_d  = 1'b0;
          oe_d  = LANES_OFF;
          we_d  = LANES_OFF;
          dqm_d = MASK_ALL;
          if (last) begin
            resp_d  = 1'b1; // R10
            state_d = ST_RESP;
          end else begin
            idx_d   = 2'(idx_q + 2'h1);
            state_d = ST_ISSUE;
          end
        end
      end
      ST_RESP: begin
        ready_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      req_q   <= REQ_RST;
      width_q <= BW_32;
      idx_q   <= 2'h0;
      rdata_q <= DATA_RST;
      ready_q <= 1'b0;
      resp_q  <= 1'b0;
      xv_q    <= 1'b0;
      xaddr_q <= DATA_RST;
      xdata_q <= DATA_RST;
      oe_q    <= LANES_OFF;
      we_q    <= LANES_OFF;
      dqm_q   <= MASK_ALL;
    end else begin
      state_q <= state_d;
      req_q   <= req_d;
      width_q <= width_d;
      idx_q   <= idx_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      resp_q  <= resp_d;
      xv_q    <= xv_d;
      xaddr_q <= xaddr_d;
      xdata_q <= xdata_d;
      oe_q    <= oe_d;
      we_q    <= we_d;
      dqm_q   <= dqm_d;
    end
  end

  always_comb begin
    req_ready          = ready_q;
    resp_valid         = resp_q;
    resp_rdata         = rdata_q;
    ext_valid          = xv_q;
    ext_write          = req_q.write;
    ext_addr           = xaddr_q;
    data_out           = xdata_q;
    data_oe            = oe_q;
    write_strobe_lane0 = we_q[0];
    write_strobe_lane1 = we_q[1];
    write_strobe_lane2 = we_q[2];
    write_strobe_lane3 = we_q[3];
    sdram_mask_lane0   = dqm_q[0];
    sdram_mask_lane1   = dqm_q[1];
    sdram_mask_lane2   = dqm_q[2];
    sdram_mask_lane3   = dqm_q[3];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic [2:0] ack_cnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_cnt_q <= 3'h0;
    end else if (state_q == ST_IDLE) begin
      ack_cnt_q <= 3'h0;
    end else if (state_q == ST_WAIT && ext_ack) begin
      ack_cnt_q <= 3'(ack_cnt_q + 3'h1);
    end
  end

  logic wr_cyc;
  assign wr_cyc = xv_q && req_q.write;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_le32_lane: assert property (wr_cyc && little_q && width_q == BW_32 // R1
    && req_q.size == SZ_BYTE |-> we_q == (4'h1 << xaddr_q[1:0]))
    else $error("little 32-bit byte on wrong lane");
  chk_le16_lanes: assert property (xv_q && little_q && width_q == BW_16 // R2
    |-> dqm_q[3:2] == 2'h3 && (req_q.size == SZ_BYTE || dqm_q[1:0] == 2'h0))
    else $error("little 16-bit lanes wrong");
  chk_le16_long: assert property (wr_cyc && little_q && width_q == BW_16 // R3
    && req_q.size == SZ_LONG |-> data_out[15:0] ==
    (xaddr_q[1] ? req_q.wdata[31:16] : req_q.wdata[15:0]))
    else $error("little 16-bit longword halves out of order");
  chk_be8_word: assert property (wr_cyc && !little_q && width_q == BW_8 // R4
    && req_q.size == SZ_WORD |-> we_q == 4'h1 && data_out[7:0] ==
    (xaddr_q[0] ? req_q.wdata[7:0] : req_q.wdata[15:8]))
    else $error("big 8-bit word bytes wrong");
  chk_be8_long: assert property (wr_cyc && !little_q && width_q == BW_8 // R5
    && req_q.size == SZ_LONG |-> data_out[7:0] == req_q.wdata[8*(3-xaddr_q[1:0])+:8])
    else $error("big 8-bit longword byte order wrong");
  chk_le8_long: assert property (wr_cyc && little_q && width_q == BW_8 // R6
    && req_q.size == SZ_LONG |-> we_q == 4'h1 && data_out[7:0] ==
    req_q.wdata[8*xaddr_q[1:0]+:8])
    else $error("little 8-bit longword byte order wrong");
  chk_be16_long: assert property (wr_cyc && !little_q && width_q == BW_16 // R7
    && req_q.size == SZ_LONG |-> we_q == 4'h3 && data_out[15:0] ==
    (xaddr_q[1] ? req_q.wdata[15:0] : req_q.wdata[31:16]))
    else $error("big 16-bit longword halves out of order");
  chk_be32_lane: assert property (wr_cyc && !little_q && width_q == BW_32 // R8
    && req_q.size == SZ_BYTE |-> we_q == (4'h8 >> xaddr_q[1:0]))
    else $error("big 32-bit byte on wrong lane");
  chk_strap_hold: assert property (strap_done_q |=> $stable(little_q)) // R9
    else $error("endianness changed after reset");
  chk_resp_count: assert property (resp_q |-> ack_cnt_q == // R10
    3'(3'h1 << (req_q.size - ((req_q.size < width_q) ? req_q.size : width_q))))
    else $error("answer before all external cycles");

  cov_long_8: cover property (resp_q && req_q.size == SZ_LONG && width_q == BW_8);
  cov_long_16: cover property (resp_q && req_q.size == SZ_LONG && width_q == BW_16);
  cov_word_32: cover property (resp_q && req_q.size == SZ_WORD && width_q == BW_32);

endmodule

// ==== rtl/ela_pkg.sv ====
// shared constants and types for the external bus lane aligner
// Contract
// R1: 32-bit little endian: offset n on lane n
// R2: 16-bit little endian: even low lane, odd lane1
// R3: 16-bit little longword: bits 15-0, then 31-16
// R4: 8-bit big endian: lane0 only, word high first
// R5: 8-bit big longword: four cycles, MSB first
// R6: 8-bit little endian: lane0, LSB byte first
// R7: 16-bit big endian: even lane1, longword high first
// R8: 32-bit big endian: offset 0 on lane 3
// R9: endianness latched from strap at reset
// R10: answer after all cycles, read data assembled
package ela_pkg;

  localparam int          LANES     = 4;
  localparam int          DATA_W    = 32;
  localparam int          ADDR_W    = 32;
  // access size and device width, both as log2 of the byte count
  localparam logic [1:0]  SZ_BYTE   = 2'h0;
  localparam logic [1:0]  SZ_WORD   = 2'h1;
  localparam logic [1:0]  SZ_LONG   = 2'h2;
  localparam logic [1:0]  BW_8      = 2'h0;
  localparam logic [1:0]  BW_16     = 2'h1;
  localparam logic [1:0]  BW_32     = 2'h2;
  localparam logic [1:0]  LANE_MASK_W16 = 2'h1;
  localparam logic [31:0] DATA_RST  = 32'h0000_0000;
  localparam logic [3:0]  LANES_OFF = 4'h0;
  localparam logic [3:0]  MASK_ALL  = 4'hf;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ISSUE = 4'h2,
    ST_WAIT  = 4'h4,
    ST_RESP  = 4'h8
  } ela_state_e;

  typedef struct packed {
    logic              write;
    logic [1:0]        size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ela_req_s;

  localparam ela_req_s REQ_RST = '{write: 1'b0, size: 2'h0, addr: 32'h0000_0000,
                                   wdata: 32'h0000_0000};

endpackage

// ==== rtl/ela_lane_map.sv ====
// byte lane steering for one external cycle of a possibly split access
`timescale 1ns/1ps
module ela_lane_map
  import ela_pkg::*;
(
  input  wire logic       little,
  input  wire logic [1:0] width,
  input  wire logic [1:0] size,
  input  wire logic [1:0] base,
  input  wire logic [1:0] cyc_idx,
  output logic [3:0]      lane_en,
  output logic [7:0]      lane_idx,
  output logic [1:0]      cyc_off,
  output logic            last
);

  logic [1:0] cw;
  logic [2:0] cyc_bytes;
  logic [2:0] ncyc;
  logic [1:0] top_idx;
  logic [3:0] j_valid;
  logic [7:0] j_lane;
  logic [7:0] j_idx;

  always_comb begin
    cw        = (size < width) ? size : width;
    cyc_bytes = 3'h1 << cw;
    ncyc      = 3'h1 << (size - cw);
    top_idx   = 2'((3'h1 << size) - 3'h1);
    cyc_off   = 2'(base + 2'(cyc_idx << cw));
    last      = (3'(cyc_idx) == 3'(ncyc - 3'h1));
  end

  // one byte of the cycle per slot: its lane on the bus and its byte of the value
  for (genvar j = 0; j < LANES; j++) begin : g_byte
    logic [1:0] a;
    logic [1:0] rel;
    always_comb begin
      a          = 2'(cyc_off + 2'(j));
      rel        = 2'(a - base);
      j_valid[j] = (3'(j) < cyc_bytes);
      j_idx[2*j+:2] = little ? rel : 2'(top_idx - rel); // R3 R4 R5 R6 R7
      case (width)
        BW_32:   j_lane[2*j+:2] = little ? a : ~a; // R1 R8
        BW_16:   j_lane[2*j+:2] = {1'b0, little ? a[0] : ~a[0]}; // R2 R7
        default: j_lane[2*j+:2] = 2'h0; // R4 R6
      endcase
    end
  end

  always_comb begin
    lane_en  = LANES_OFF;
    lane_idx = 8'h00;
    for (int j = 0; j < LANES; j++) begin
      if (j_valid[j]) begin
        lane_en[j_lane[2*j+:2]]         = 1'b1;
        lane_idx[2*j_lane[2*j+:2]+:2]   = j_idx[2*j+:2];
      end
    end
  end

endmodule

// ==== testbench/ela_mem_model.sv ====
// external memory model answering one lane-steered cycle at a time
`timescale 1ns/1ps
module ela_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  ack_delay,
  input  wire logic        ext_valid,
  input  wire logic        ext_write,
  input  wire logic [31:0] ext_addr,
  input  wire logic [31:0] data_out,
  input  wire logic [3:0]  strobe,
  input  wire logic [3:0]  mask,
  output logic [31:0]      data_in,
  output logic             ext_ack
);
  logic [7:0] mem_q [0:15][0:3];
  logic [1:0] wait_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_ack <= 1'b0;
      wait_q  <= 2'h0;
      data_in <= 32'h0000_0000;
    end else begin
      // lanes not driven toggle so a stale value never passes
      data_in <= ~data_in;
      if (ext_valid && !ext_ack) begin
        for (int l = 0; l < 4; l++) begin
          if (!mask[l]) data_in[l*8+:8] <= mem_q[ext_addr[3:0]][l];
        end
        ext_ack <= (wait_q == ack_delay);
        wait_q  <= wait_q + 2'h1;
      end else begin
        ext_ack <= 1'b0;
        wait_q  <= 2'h0;
      end
      if (ext_valid && ext_ack && ext_write) begin
        for (int l = 0; l < 4; l++) begin
          if (strobe[l]) mem_q[ext_addr[3:0]][l] <= data_out[l*8+:8];
        end
      end
    end
  end
endmodule

// ==== testbench/ela_aligner_test.sv ====
// self-checking bench for the lane aligner against a memory model
`timescale 1ns/1ps
module ela_aligner_test;
  import ela_pkg::*;
  logic        clk       = 1'b0;
  logic        rst_b     = 1'b0;
  logic        strap     = 1'b0;
  logic        lt        = 1'b0;
  logic [1:0]  bw        = 2'h0;
  logic [1:0]  dly       = 2'h0;
  logic        req_valid = 1'b0;
  ela_req_s    req       = REQ_RST;
  logic        req_ready, resp_valid, ext_valid, ext_write, ext_ack;
  logic [31:0] resp_rdata, ext_addr, data_out, data_in;
  logic [3:0]  data_oe, we, dm;
  int          fails       = 0;
  int          comparisons = 0;

  always #5 clk = ~clk;

  ela_aligner u_dut (.clk(clk), .rst_b(rst_b), .endian_strap_pin(strap), .bus_width(bw),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .ext_valid(ext_valid), .ext_write(ext_write),
    .ext_addr(ext_addr), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .ext_ack(ext_ack), .write_strobe_lane0(we[0]), .write_strobe_lane1(we[1]),
    .write_strobe_lane2(we[2]), .write_strobe_lane3(we[3]), .sdram_mask_lane0(dm[0]),
    .sdram_mask_lane1(dm[1]), .sdram_mask_lane2(dm[2]), .sdram_mask_lane3(dm[3]));

  ela_mem_model u_mem (.clk(clk), .rst_b(rst_b), .ack_delay(dly), .ext_valid(ext_valid),
    .ext_write(ext_write), .ext_addr(ext_addr), .data_out(data_out), .strobe(we),
    .mask(dm), .data_in(data_in), .ext_ack(ext_ack));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one access; every external cycle is judged at its ack edge
  task automatic access(input logic wr, input logic [1:0] sz, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
    int nb, cb, k, t, ab, o, ln, bi;
    logic [31:0] exd;
    logic [3:0]  exs;
    @(posedge clk);
    nb = 1 << sz;
    cb = (nb < (1 << bw)) ? nb : (1 << bw);
    k  = 0;
    req_valid <= 1'b1;
    req       <= '{write: wr, size: sz, addr: a, wdata: wd};
    for (t = 0; t < 50; t++) begin
      @(posedge clk);
      if (req_ready === 1'b1) break;
    end
    if (t >= 50) begin
      fails++;
      end_sim();
    end
    req_valid <= 1'b0;
    for (t = 0; t < 200 && t >= 0; t++) begin
      @(negedge clk);
      if (resp_valid === 1'b1) break;
      check({31'h0, req_ready}, 32'h0000_0000);
      if (ext_valid === 1'b1 && ext_ack === 1'b1) begin
        exd = 32'h0000_0000;
        exs = 4'h0;
        for (ab = k * cb; ab < (k + 1) * cb; ab++) begin
          o  = (a[1:0] + ab) % 4;
          ln = (bw == 2) ? (lt ? o : 3 - o) : (bw == 1) ? (lt ? o % 2 : 1 - o % 2) : 0;
          bi = lt ? ab : nb - 1 - ab;
          exs[ln] = 1'b1;
          exd[ln*8+:8] = wd[bi*8+:8];
        end
        check(ext_addr, a + 32'(k * cb));
        check({31'h0, ext_write}, {31'h0, wr});
        check({24'h0, we, data_oe}, wr ? {24'h0, exs, exs} : 32'h0000_0000);
        check({28'h0, dm}, {28'h0, ~exs});
        if (wr) check(data_out, exd);
        k++;
      end
    end
    if (t >= 200) begin
      fails++;
      end_sim();
    end
    check(32'(k), 32'(nb / cb));
    rd = resp_rdata;
  endtask

  // reset with a strap level, then every width, size and aligned offset
  task automatic run_mode(input logic l);
    logic [31:0] wd, rd;
    @(posedge clk);
    lt    = l;
    strap <= l;
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    check({26'h0, ext_valid, req_ready, dm}, 32'h0000_000f);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    strap <= ~l;
    for (int w = 0; w < 3; w++) begin
      for (int s = 0; s < 3; s++) begin
        for (int o = 0; o < 4; o += (1 << s)) begin
          @(posedge clk);
          bw  <= 2'(w);
          dly <= 2'(((w + s + o) % 2) * 3);
          wd  = 32'ha1b2_c3d4 + 32'(o) * 32'h0101_0101 + 32'(w * 16 + s);
          access(1'b1, 2'(s), 32'h0000_0010 + 32'(o), wd, rd);
          access(1'b0, 2'(s), 32'h0000_0010 + 32'(o), 32'h0000_0000, rd);
          check(rd, wd & (32'hffff_ffff >> (32 - 8 * (1 << s))));
        end
      end
    end
  endtask

  initial begin
    run_mode(1'b0);
    run_mode(1'b1);
    end_sim();
  end
endmodule
